// >>> hw/sys_glue.sv
`timescale 1ns/1ps
// Functional notes
// - rts control bit set drives the request-to-send pin low.
// - async with auto enables: pin rises only once transmitter is empty.
// - otherwise the pin mirrors the rts bit directly, usable as output.
// - terminal-ready pin always mirrors the dtr control bit.
// - serial wait is wired-or onto the shared low-active wait line.
// - dma requests stay internal; requests and terminal counts not on pins.
// - chain enable out high only when chain in high and no on-chip service.
// - io select covers aligned groups of eight holding no on-chip register.
// - io decode follows register-set relocation and decode-high-io bit.
// - unrelocated, dhio 0: xx40-xxd7, xxf8-xxff, nn00-nn3f for nn nonzero.
// - unrelocated, dhio 1: 0040-00d7 and 00f8-ffff.
// - io decode identical under internal cpu or external bus master.
// - ram select low for memory accesses between ram bounds.
// - rom select low from top of on-chip rom up to rom boundary.
// - ram and rom selects decode under external master as well.
// - system clock is input divided by two, or by one when programmed.
// - mode 11 selects request source by upper address bits code.
// - each dma channel takes all sources in both directions.
// - while wait line sampled low the cpu keeps adding wait states.
module sys_glue #(
  parameter int         ADDR_W  = 20,    // memory address width
  parameter logic [7:0] ROM_TOP = 8'h08  // first 4k page above on-chip rom
) (
  input  wire logic              clock_i,          // core clock
  input  wire logic              nrst_i,           // async reset, low
  input  wire logic [3:0]        reg_addr_i,       // register index
  input  wire logic [7:0]        reg_wdata_i,      // register write data
  input  wire logic              reg_wr_i,         // write strobe
  input  wire logic              reg_rd_i,         // read strobe
  output logic      [7:0]        reg_rdata_o,      // read data, next cycle
  input  wire logic [ADDR_W-1:0] addr_i,           // bus address, any master
  input  wire logic              io_request_n_i,   // io request, low
  input  wire logic              mreq_n_i,         // memory request, low
  input  wire logic              opcode_fetch_n_i, // opcode fetch, low
  input  wire logic              tx_empty_i,       // serial transmitter empty
  input  wire logic              serial_wait_i,    // serial wait request
  input  wire logic              other_wait_i,     // other internal waits
  input  wire logic              wait_pin_i,       // wait wire level
  output logic                   wait_pin_o,       // wait pin drive value
  output logic                   wait_oe_n_o,      // wait drive enable, low
  output logic                   cpu_hold_o,       // insert wait state
  output logic                   rts_n_o,          // request to send, low
  output logic                   dtr_n_o,          // terminal ready, low
  input  wire logic              chain_enable_in_i,  // daisy chain in
  input  wire logic              onchip_service_i,   // on-chip irq in service
  output logic                   chain_enable_out_o, // daisy chain out
  output logic                   ext_io_select_n_o,  // external io select
  output logic                   ram_select_n_o,     // ram select, low
  output logic                   rom_select_n_o,     // rom select, low
  output logic                   system_clock_out_o, // system clock level
  output logic                   sys_tick_o,         // one pulse per sys cycle
  input  wire logic              ext_req_n_i,        // external dma request
  input  wire logic [1:0]        async0_req_i,       // async 0 rx/tx
  input  wire logic [1:0]        async1_req_i,       // async 1 rx/tx
  input  wire logic [1:0]        serial_req_i,       // serial rx/tx
  input  wire logic [1:0]        par2_req_i,         // parallel in/out
  output logic      [1:0]        dma_req_o           // per channel, internal
);
  // refuse address widths the page and io decode cannot serve
  if (ADDR_W < 16 || ADDR_W > 24) begin : g_bad_addr_w
    $error("ADDR_W out of range");
  end

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_n;

  // two-stage release of the async reset; low time is outside's duty
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  logic [7:0] ser_ctrl_r;
  logic [7:0] sys_cfg_r;
  logic [1:0] io_reloc_r;
  logic [7:0] ram_lo_r;
  logic [7:0] ram_hi_r;
  logic [7:0] rom_bnd_r;
  logic [7:0] rom_cfg_r;
  logic [4:0] dma_cfg_r [4];

  // control register writes
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ser_ctrl_r <= glue_pkg::SER_CTRL_RST;
      sys_cfg_r  <= glue_pkg::SYS_CFG_RST;
      io_reloc_r <= glue_pkg::IO_RELOC_RST;
      ram_lo_r   <= glue_pkg::RAM_LO_RST;
      ram_hi_r   <= glue_pkg::RAM_HI_RST;
      rom_bnd_r  <= glue_pkg::ROM_BND_RST;
      rom_cfg_r  <= glue_pkg::ROM_CFG_RST;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        glue_pkg::SER_CTRL_OFS: ser_ctrl_r <= reg_wdata_i;
        glue_pkg::SYS_CFG_OFS:  sys_cfg_r  <= reg_wdata_i;
        glue_pkg::IO_RELOC_OFS: io_reloc_r <= reg_wdata_i[1:0];
        glue_pkg::RAM_LO_OFS:   ram_lo_r   <= reg_wdata_i;
        glue_pkg::RAM_HI_OFS:   ram_hi_r   <= reg_wdata_i;
        glue_pkg::ROM_BND_OFS:  rom_bnd_r  <= reg_wdata_i;
        glue_pkg::ROM_CFG_OFS:  rom_cfg_r  <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // dma source and destination selects
  generate
    for (genvar g = 0; g < 4; g++) begin : g_dma_cfg
      always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
          dma_cfg_r[g] <= 5'h00;
        end else if (reg_wr_i && reg_addr_i == glue_pkg::DMA_BASE_OFS + 4'(g)) begin
          dma_cfg_r[g] <= reg_wdata_i[4:0];
        end
      end
    end
  endgenerate

  logic rts_bit;
  logic auto_mode;
  assign rts_bit   = ser_ctrl_r[glue_pkg::SER_RTS_BIT];
  assign auto_mode = ser_ctrl_r[glue_pkg::SER_ASYNC_BIT] & ser_ctrl_r[glue_pkg::SER_AUTO_BIT];

  // read data, valid the cycle after the strobe
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        glue_pkg::SER_CTRL_OFS: reg_rdata_o <= ser_ctrl_r;
        glue_pkg::SYS_CFG_OFS:  reg_rdata_o <= sys_cfg_r;
        glue_pkg::IO_RELOC_OFS: reg_rdata_o <= {6'h00, io_reloc_r};
        glue_pkg::RAM_LO_OFS:   reg_rdata_o <= ram_lo_r;
        glue_pkg::RAM_HI_OFS:   reg_rdata_o <= ram_hi_r;
        glue_pkg::ROM_BND_OFS:  reg_rdata_o <= rom_bnd_r;
        glue_pkg::ROM_CFG_OFS:  reg_rdata_o <= rom_cfg_r;
        glue_pkg::DMA_BASE_OFS, glue_pkg::DMA_BASE_OFS + 4'h1,
        glue_pkg::DMA_BASE_OFS + 4'h2, glue_pkg::DMA_BASE_OFS + 4'h3:
                                reg_rdata_o <= {3'h0, dma_cfg_r[2'(reg_addr_i - glue_pkg::DMA_BASE_OFS)]};
        glue_pkg::STATUS_OFS:   reg_rdata_o <= {2'h0, dma_req_o, cpu_hold_o, chain_enable_out_o,
                                                dtr_n_o, rts_n_o};
        default:                reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------
  // modem control pins
  // ----------------------------------------
  // rts: set drives low; auto mode holds low until transmitter drains
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rts_n_o <= 1'b1;
    end else if (rts_bit) begin
      rts_n_o <= 1'b0;
    end else if (auto_mode) begin
      rts_n_o <= rts_n_o | tx_empty_i;
    end else begin
      rts_n_o <= 1'b1;
    end
  end

  // dtr follows its bit, nothing else shares the pin
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      dtr_n_o <= 1'b1;
    end else begin
      dtr_n_o <= ~ser_ctrl_r[glue_pkg::SER_DTR_BIT];
    end
  end

  // ----------------------------------------
  // wait line
  // ----------------------------------------
  // open-drain drive of the merged internal waits, then cpu hold
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      wait_pin_o  <= 1'b0;
      wait_oe_n_o <= 1'b1;
      cpu_hold_o  <= 1'b0;
    end else begin
      wait_pin_o  <= 1'b0;
      wait_oe_n_o <= ~(serial_wait_i | other_wait_i);
      cpu_hold_o  <= ~wait_pin_i;
    end
  end

  // ----------------------------------------
  // daisy chain
  // ----------------------------------------
  // pass the chain enable only when no on-chip interrupt is in service
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      chain_enable_out_o <= 1'b0;
    end else begin
      chain_enable_out_o <= chain_enable_in_i & ~onchip_service_i;
    end
  end

  // ----------------------------------------
  // chip selects
  // ----------------------------------------
  logic [7:0] io_hi;
  logic [7:0] io_lo;
  logic       core_hit;
  logic       periph_hit;
  logic       io_internal;
  logic       io_ext_nxt;
  logic [7:0] page;
  logic       ram_nxt;
  logic       rom_nxt;

  assign io_hi = addr_i[15:8];
  assign io_lo = addr_i[7:0];
  // core register set: 64 bytes at the relocated base
  assign core_hit   = (io_lo[7:6] == io_reloc_r);
  // fixed on-chip block d8..f7, eight-aligned both ends
  assign periph_hit = (io_lo >= 8'hd8) && (io_lo <= 8'hf7);
  // dhio 0 aliases the fixed block in every page, dhio 1 frees high pages
  always_comb begin
    if (sys_cfg_r[glue_pkg::CFG_DHIO_BIT]) begin
      io_internal = (io_hi == 8'h00) && (core_hit || periph_hit);
    end else begin
      io_internal = periph_hit || ((io_hi == 8'h00) && core_hit);
    end
  end
  // no master-ownership term: same decode for any master
  assign io_ext_nxt = ~io_request_n_i & opcode_fetch_n_i & ~io_internal;

  assign page    = addr_i[ADDR_W-1 -: 8];
  assign ram_nxt = ~mreq_n_i && (page >= ram_lo_r) && (page <= ram_hi_r);
  assign rom_nxt = ~mreq_n_i && ~ram_nxt && (page <= rom_bnd_r)
                   && (!rom_cfg_r[glue_pkg::ROM_EN_BIT] || page >= ROM_TOP);

  // registered selects, idle when no request
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_io_select_n_o <= 1'b1;
      ram_select_n_o    <= 1'b1;
      rom_select_n_o    <= 1'b1;
    end else begin
      ext_io_select_n_o <= ~io_ext_nxt;
      ram_select_n_o    <= ~ram_nxt;
      rom_select_n_o    <= ~rom_nxt;
    end
  end

  // ----------------------------------------
  // system clock divider
  // ----------------------------------------
  logic div1;
  assign div1 = sys_cfg_r[glue_pkg::CFG_DIV1_BIT];

  // tick every cycle when div1, else every other; level toggles per tick
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sys_tick_o         <= 1'b0;
      system_clock_out_o <= 1'b0;
    end else begin
      sys_tick_o         <= div1 | ~sys_tick_o;
      system_clock_out_o <= div1 ? ~system_clock_out_o :
                            (sys_tick_o ? system_clock_out_o : ~system_clock_out_o);
    end
  end

  // ----------------------------------------
  // dma request routing
  // ----------------------------------------
  function automatic logic pick(input logic [4:0] cfg, input logic dir_tx,
                                input logic ext, input logic [1:0] a0, input logic [1:0] a1,
                                input logic [1:0] sr, input logic [1:0] p2);
    logic hit;
    hit = 1'b0;
    if (cfg[glue_pkg::DMA_MODE_LSB +: 2] == glue_pkg::DMA_IO_MODE) begin
      unique case (cfg[glue_pkg::DMA_SEL_LSB +: 3])
        glue_pkg::SEL_EXT:    hit = ext;
        glue_pkg::SEL_ASYNC0: hit = a0[dir_tx];
        glue_pkg::SEL_ASYNC1: hit = a1[dir_tx];
        glue_pkg::SEL_SERIAL: hit = sr[dir_tx];
        glue_pkg::SEL_PAR2:   hit = p2[dir_tx];
        default:              hit = 1'b0; // reserved codes request nothing
      endcase
    end
    return hit;
  endfunction

  // two channels, each with source (rx side) and destination (tx side)
  generate
    for (genvar c = 0; c < 2; c++) begin : g_dma_ch
      always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
          dma_req_o[c] <= 1'b0;
        end else begin
          dma_req_o[c] <= pick(dma_cfg_r[2*c], 1'b0, ~ext_req_n_i, async0_req_i, async1_req_i,
                               serial_req_i, par2_req_i)
                        | pick(dma_cfg_r[2*c+1], 1'b1, ~ext_req_n_i, async0_req_i, async1_req_i,
                               serial_req_i, par2_req_i);
        end
      end
    end
  endgenerate
  // dma_req_o feeds the on-chip controller only; reserved codes give no request

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_rts_release;
    !rts_bit && auto_mode && !rts_n_o && !tx_empty_i;
  endsequence
  sequence s_div2_tick;
    !div1 && sys_tick_o;
  endsequence

  a_rts_set_low: assert property (@(posedge clock_i) disable iff (!rst_n)
    rts_bit |=> !rts_n_o) else $error("rts pin not low with bit set");
  a_rts_hold_auto: assert property (@(posedge clock_i) disable iff (!rst_n)
    s_rts_release |=> !rts_n_o) else $error("rts rose before transmitter empty");
  a_rts_mirror: assert property (@(posedge clock_i) disable iff (!rst_n)
    !auto_mode |=> rts_n_o == !$past(rts_bit)) else $error("rts pin not mirroring bit");
  a_dtr_mirror: assert property (@(posedge clock_i) disable iff (!rst_n)
    ##1 dtr_n_o == !$past(ser_ctrl_r[glue_pkg::SER_DTR_BIT])) else $error("dtr pin wrong");
  a_wait_drive: assert property (@(posedge clock_i) disable iff (!rst_n)
    serial_wait_i |=> !wait_oe_n_o && !wait_pin_o) else $error("serial wait not driven");
  a_wait_hold: assert property (@(posedge clock_i) disable iff (!rst_n)
    !wait_pin_i |=> cpu_hold_o) else $error("no wait state on low wait line");
  a_chain_out: assert property (@(posedge clock_i) disable iff (!rst_n)
    ##1 chain_enable_out_o == ($past(chain_enable_in_i) && !$past(onchip_service_i)))
    else $error("chain enable out wrong");
  a_io_idle: assert property (@(posedge clock_i) disable iff (!rst_n)
    io_request_n_i |=> ext_io_select_n_o) else $error("io select without request");
  a_io_low_map: assert property (@(posedge clock_i) disable iff (!rst_n)
    (!io_request_n_i && opcode_fetch_n_i && io_reloc_r == 2'h0 && !sys_cfg_r[1]
     && io_hi != 8'h00 && io_lo < 8'h40) |=> !ext_io_select_n_o) else $error("nn00-nn3f not selected");
  a_ram_window: assert property (@(posedge clock_i) disable iff (!rst_n)
    (!mreq_n_i && page >= ram_lo_r && page <= ram_hi_r) |=> !ram_select_n_o && rom_select_n_o)
    else $error("ram select missing");
  a_div_two: assert property (@(posedge clock_i) disable iff (!rst_n)
    s_div2_tick ##1 !div1 |-> !sys_tick_o) else $error("divide by two tick wrong");
  a_dma_reserved: assert property (@(posedge clock_i) disable iff (!rst_n)
    (dma_cfg_r[0] == 5'h1c && dma_cfg_r[1][4:3] != 2'h3) |=> !dma_req_o[0])
    else $error("reserved code raised a request");

  // channel 0 destination set to the serial transmit request
  sequence s_dst_serial_req;
    dma_cfg_r[1] == {glue_pkg::DMA_IO_MODE, glue_pkg::SEL_SERIAL} && serial_req_i[1];
  endsequence

  a_io_high_map: assert property (@(posedge clock_i) disable iff (!rst_n)
    (!io_request_n_i && opcode_fetch_n_i && io_reloc_r == 2'h0 && sys_cfg_r[glue_pkg::CFG_DHIO_BIT]
     && io_hi != 8'h00) |=> !ext_io_select_n_o) else $error("high io page not selected");
  a_rom_window: assert property (@(posedge clock_i) disable iff (!rst_n)
    (!mreq_n_i && page >= ROM_TOP && page <= rom_bnd_r && !(page >= ram_lo_r && page <= ram_hi_r))
    |=> !rom_select_n_o) else $error("rom select missing");
  a_rom_onchip: assert property (@(posedge clock_i) disable iff (!rst_n)
    (rom_cfg_r[glue_pkg::ROM_EN_BIT] && page < ROM_TOP) |=> rom_select_n_o)
    else $error("rom select over on-chip rom");
  a_mem_idle: assert property (@(posedge clock_i) disable iff (!rst_n)
    mreq_n_i |=> ram_select_n_o && rom_select_n_o) else $error("memory select without request");
  a_dma_dest: assert property (@(posedge clock_i) disable iff (!rst_n)
    s_dst_serial_req |=> dma_req_o[0]) else $error("destination request not routed");
endmodule

// >>> hw/glue_pkg.sv
package glue_pkg;
  // ----------------------------------------
  // register offsets (index on the port)
  // ----------------------------------------
  localparam logic [3:0] SER_CTRL_OFS = 4'h0;
  localparam logic [3:0] SYS_CFG_OFS  = 4'h1;
  localparam logic [3:0] IO_RELOC_OFS = 4'h2;
  localparam logic [3:0] RAM_LO_OFS   = 4'h3;
  localparam logic [3:0] RAM_HI_OFS   = 4'h4;
  localparam logic [3:0] ROM_BND_OFS  = 4'h5;
  localparam logic [3:0] ROM_CFG_OFS  = 4'h6;
  localparam logic [3:0] DMA_BASE_OFS = 4'h7; // src0, dst0, src1, dst1
  localparam logic [3:0] STATUS_OFS   = 4'hb;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SER_RTS_BIT   = 0;
  localparam int SER_DTR_BIT   = 1;
  localparam int SER_ASYNC_BIT = 2;
  localparam int SER_AUTO_BIT  = 3;
  localparam int CFG_DIV1_BIT  = 0;
  localparam int CFG_DHIO_BIT  = 1;
  localparam int ROM_EN_BIT    = 0;
  localparam int DMA_SEL_LSB   = 0; // upper address bits [2:0]
  localparam int DMA_MODE_LSB  = 3; // mode field [4:3]
  // ----------------------------------------
  // reset values and codes
  // ----------------------------------------
  localparam logic [7:0] SER_CTRL_RST = 8'h00;
  localparam logic [7:0] SYS_CFG_RST  = 8'h00; // divide by two, dhio 0
  localparam logic [1:0] IO_RELOC_RST = 2'h0;  // not relocated
  localparam logic [7:0] RAM_LO_RST   = 8'hff;
  localparam logic [7:0] RAM_HI_RST   = 8'h00;
  localparam logic [7:0] ROM_BND_RST  = 8'hff;
  localparam logic [7:0] ROM_CFG_RST  = 8'h01;
  localparam logic [1:0] DMA_IO_MODE  = 2'h3;
  localparam logic [2:0] SEL_EXT      = 3'h0;
  localparam logic [2:0] SEL_ASYNC0   = 3'h1;
  localparam logic [2:0] SEL_ASYNC1   = 3'h2;
  localparam logic [2:0] SEL_SERIAL   = 3'h3;
  localparam logic [2:0] SEL_PAR2     = 3'h7;
  localparam int         RESET_MIN_CYC = 3;
endpackage

// >>> dv/ext_wait_dev.sv
`timescale 1ns/1ps
// ----------------------------------------
// slow external device on the wait wire
// ----------------------------------------
module ext_wait_dev (
  input  wire logic       clock_i, // core clock
  input  wire logic [3:0] slow_i,  // wait cycles to insert
  input  wire logic       go_i,    // access to the slow device
  input  wire logic       pin_i,   // design drive value
  input  wire logic       oe_n_i,  // design drive enable, low
  output logic            wire_o   // resolved wait level
);
  logic [3:0] left_r = 4'h0;
  // count down the wait cycles still owed
  always_ff @(posedge clock_i) begin
    if (go_i) begin
      left_r <= slow_i;
    end else if (left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
    end
  end
  // open drain with pull-up: any low driver wins
  assign wire_o = ~((~oe_n_i & ~pin_i) | (left_r != 4'h0));
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clock_i, nrst_i, wr, rd, io_request_n, mreq_n, m1_n, txe, swt, owt, cei, svc, dreq_n, go, prev;
  logic [3:0]  ra, slow;
  logic [7:0]  wd, rdat, v8;
  logic [19:0] addr;
  logic [1:0]  a0, a1, sr, p2, dreq;
  logic        wlvl, wo, woe_n, hold, rts_n, dtr_n, ceo, ios_n, rams_n, roms_n, sco, tick;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          flips, ticks;
  logic [7:0]  rst_e [7] = '{glue_pkg::SER_CTRL_RST, glue_pkg::SYS_CFG_RST, {6'h0, glue_pkg::IO_RELOC_RST},
                             glue_pkg::RAM_LO_RST, glue_pkg::RAM_HI_RST, glue_pkg::ROM_BND_RST, glue_pkg::ROM_CFG_RST};
  logic [2:0]  codes [5] = '{glue_pkg::SEL_EXT, glue_pkg::SEL_ASYNC0, glue_pkg::SEL_ASYNC1, glue_pkg::SEL_SERIAL,
                             glue_pkg::SEL_PAR2};
  logic [15:0] io_a [9]  = '{16'h0040, 16'h00d7, 16'h00d8, 16'h00f8, 16'h0000, 16'h0100, 16'h013f, 16'h01e0, 16'hffe0};
  logic [1:0]  io_e [9]  = '{2'b00, 2'b00, 2'b11, 2'b00, 2'b11, 2'b00, 2'b00, 2'b01, 2'b01};
  logic [19:0] mem_a [6] = '{20'h10000, 20'h1ffff, 20'h20000, 20'h08000, 20'h07fff, 20'h0ffff};
  logic [7:0]  mem_e [6] = '{8'h05, 8'h05, 8'h07, 8'h06, 8'h07, 8'h06};

  // clock source
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  sys_glue i_dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .addr_i(addr), .io_request_n_i(io_request_n), .mreq_n_i(mreq_n), .opcode_fetch_n_i(m1_n),
    .tx_empty_i(txe), .serial_wait_i(swt), .other_wait_i(owt), .wait_pin_i(wlvl), .wait_pin_o(wo),
    .wait_oe_n_o(woe_n), .cpu_hold_o(hold), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .chain_enable_in_i(cei),
    .onchip_service_i(svc), .chain_enable_out_o(ceo), .ext_io_select_n_o(ios_n), .ram_select_n_o(rams_n),
    .rom_select_n_o(roms_n), .system_clock_out_o(sco), .sys_tick_o(tick), .ext_req_n_i(dreq_n),
    .async0_req_i(a0), .async1_req_i(a1), .serial_req_i(sr), .par2_req_i(p2), .dma_req_o(dreq));

  ext_wait_dev i_dev (.clock_i(clock_i), .slow_i(slow), .go_i(go), .pin_i(wo), .oe_n_i(woe_n), .wire_o(wlvl));

  // ----------------------------------------
  // bus tasks and checking
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_i);
    ra <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    d = rdat;
  endtask
  // drive an address, compare the three selects
  task automatic probe(input logic [19:0] a, input logic [7:0] e);
    @(posedge clock_i);
    addr <= a;
    cyc(2);
    chk({5'h0, ios_n, rams_n, roms_n}, e);
  endtask
  // bounded wait for the hold flag, then compare
  task automatic wait_hold(input logic v);
    for (int k = 0; k < 12 && hold !== v; k++) cyc(1);
    chk({7'h0, hold}, {7'h0, v});
    if (hold !== v) summarize();
  endtask
  // one source/direction alone, or every other one
  task automatic drive_src(input int k, input int b, input logic inv);
    logic [9:0] v;
    v = 10'h0;
    v[k * 2 + b] = 1'b1;
    v = inv ? ~v : v;
    @(posedge clock_i);
    dreq_n <= ~(inv ? (v[0] & v[1]) : (v[0] | v[1]));
    a0 <= v[3:2];
    a1 <= v[5:4];
    sr <= v[7:6];
    p2 <= v[9:8];
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    nrst_i = 1'b0;
    {ra, wd, addr, slow} = 36'h0;
    {wr, rd, go, swt, owt, cei, svc, txe} = 8'h0;
    {io_request_n, mreq_n, m1_n, dreq_n} = 4'hf;
    {a0, a1, sr, p2} = 8'h00;
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    for (int i = 0; i < 7; i++) begin
      rreg(4'(i), v8);
      chk(v8, rst_e[i]);
    end
    wreg(4'hc, 8'h5a);
    rreg(4'hc, v8);
    chk(v8, 8'h00);
    $display("test reset done");
    for (int d = 0; d < 2; d++) begin
      if (d == 1) wreg(glue_pkg::SYS_CFG_OFS, 8'h01);
      cyc(2);
      flips = 0;
      ticks = 0;
      repeat (8) begin
        prev = sco;
        cyc(1);
        flips += int'(sco !== prev);
        ticks += int'(tick === 1'b1);
      end
      chk(8'(flips), 8'(4 * (d + 1)));
      chk(8'(ticks), 8'(4 * (d + 1)));
    end
    $display("test clock done");
    @(posedge clock_i);
    io_request_n <= 1'b0;
    for (int d = 0; d < 2; d++) begin
      wreg(glue_pkg::SYS_CFG_OFS, 8'(d * 2));
      for (int i = 0; i < 9; i++) probe({4'h0, io_a[i]}, {5'h0, io_e[i][d], 2'b11});
    end
    wreg(glue_pkg::SYS_CFG_OFS, 8'h00);
    wreg(glue_pkg::IO_RELOC_OFS, 8'h01);
    probe(20'h00000, 8'h03);
    probe(20'h00040, 8'h07);
    wreg(glue_pkg::IO_RELOC_OFS, 8'h00);
    @(posedge clock_i);
    m1_n <= 1'b0;
    probe(20'h00140, 8'h07);
    @(posedge clock_i);
    {m1_n, io_request_n} <= 2'b11;
    probe(20'h00141, 8'h07);
    $display("test io done");
    @(posedge clock_i);
    mreq_n <= 1'b0;
    wreg(glue_pkg::RAM_LO_OFS, 8'h10);
    wreg(glue_pkg::RAM_HI_OFS, 8'h1f);
    wreg(glue_pkg::ROM_BND_OFS, 8'h0f);
    rreg(glue_pkg::RAM_HI_OFS, v8);
    chk(v8, 8'h1f);
    for (int i = 0; i < 6; i++) probe(mem_a[i], mem_e[i]);
    wreg(glue_pkg::ROM_CFG_OFS, 8'h00);
    probe(20'h00000, 8'h06);
    @(posedge clock_i);
    mreq_n <= 1'b1;
    probe(20'h10000, 8'h07);
    $display("test memory done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      {cei, svc} <= 2'(i);
      cyc(2);
      chk({7'h0, ceo}, {7'h0, 1'(i == 2)});
    end
    wreg(glue_pkg::SER_CTRL_OFS, 8'h03);
    cyc(2);
    chk({6'h0, rts_n, dtr_n}, 8'h00);
    wreg(glue_pkg::SER_CTRL_OFS, 8'h00);
    cyc(2);
    chk({6'h0, rts_n, dtr_n}, 8'h03);
    rreg(glue_pkg::STATUS_OFS, v8);
    chk(v8, 8'h03);
    wreg(glue_pkg::SER_CTRL_OFS, 8'h0d);
    wreg(glue_pkg::SER_CTRL_OFS, 8'h0c);
    cyc(5);
    chk({7'h0, rts_n}, 8'h00);
    @(posedge clock_i);
    txe <= 1'b1;
    cyc(2);
    chk({7'h0, rts_n}, 8'h01);
    @(posedge clock_i);
    txe <= 1'b0;
    wreg(glue_pkg::SER_CTRL_OFS, 8'h09);
    wreg(glue_pkg::SER_CTRL_OFS, 8'h08);
    cyc(2);
    chk({7'h0, rts_n}, 8'h01);
    $display("test modem pins done");
    @(posedge clock_i);
    swt <= 1'b1;
    cyc(2);
    chk({6'h0, woe_n, wo}, 8'h00);
    wait_hold(1'b1);
    @(posedge clock_i);
    {swt, owt} <= 2'b01;
    cyc(2);
    chk({7'h0, woe_n}, 8'h00);
    @(posedge clock_i);
    owt <= 1'b0;
    wait_hold(1'b0);
    @(posedge clock_i);
    {slow, go} <= 5'hd;
    @(posedge clock_i);
    go <= 1'b0;
    wait_hold(1'b1);
    chk({7'h0, woe_n}, 8'h01);
    wait_hold(1'b0);
    $display("test wait done");
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 5; k++) begin
        wreg(4'(glue_pkg::DMA_BASE_OFS + r), {3'h0, glue_pkg::DMA_IO_MODE, codes[k]});
        drive_src(k, r % 2, 1'b0);
        cyc(2);
        chk({6'h0, dreq}, 8'(1 << (r / 2)));
        drive_src(k, r % 2, 1'b1);
        cyc(2);
        chk({6'h0, dreq}, 8'h00);
      end
      wreg(4'(glue_pkg::DMA_BASE_OFS + r), 8'h00);
    end
    for (int c = 4; c < 8; c++) begin
      wreg(glue_pkg::DMA_BASE_OFS, (c == 7) ? 8'h11 : {3'h0, glue_pkg::DMA_IO_MODE, 3'(c)});
      @(posedge clock_i);
      {dreq_n, a0, a1, sr, p2} <= 9'h0ff;
      cyc(2);
      chk({6'h0, dreq}, 8'h00);
    end
    $display("test dma done");
    summarize();
  end
endmodule
